// *** verilog/pllcg_top.sv ***
// Contract
// - prescale input clock by 1 to 32, multiply by 4 to 25 in the pll; the multiplier field accepts and passes on any value 0 to 31.
// - oscillator divider 1 to 32 drives clock out three, enable bit 15 set.
// - path select 0 uses the input clock, 1 uses the pll output.
// - core, bus and memory clocks each have their own post divider.
// - memory interface clocked from external pin or third post divider by select.
// - clock out two follows bus clock when its divider and bit 3 enabled.
// - memory clock out from third divider by default, bit 4 selects pin.
// - ratio field is value plus one, resets /1 /1 /2 /2.
// - after reset the pll reset reads asserted and path reads bypass.
// - multiplier field five bits wide, resets to factor seven.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pllcg_params.svh"

module pllcg_top
  import pllcg_pkg::*;
#(
  parameter int LOCK_CYCLES = `PLLCG_LOCK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pll_output_tick,
  input wire logic memory_clk_in,
  output logic pll_reference,
  output logic [4:0] multiply_factor,
  output logic pll_reset_ctl,
  output logic pll_power_down,
  output logic core_clk,
  output logic periph_bus_clk,
  output logic memory_clk,
  output logic clk_out_two,
  output logic clk_out_three,
  output logic memory_clk_out
);

  localparam int NDIV = 5;
  localparam int PRE = 0;
  localparam int CORE = 1;
  localparam int BUS = 2;
  localparam int MEM = 3;
  localparam int OSC = 4;
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (rst);

  function automatic logic [5:0] high_len(input logic [4:0] ratio);
    // high for ceil(n/2) ticks of an n tick period
    high_len = 6'((7'(ratio) + 7'h02) >> 1);
  endfunction : high_len
  function automatic pllcg_word_t wmask(input logic [3:0] idx);
    case (idx)
      `PLLCG_IDX_CSR: wmask = `PLLCG_MASK_CSR;
      `PLLCG_IDX_MULT: wmask = `PLLCG_MASK_MULT;
      `PLLCG_IDX_DEVICE_CONFIG: wmask = `PLLCG_MASK_DEVICE_CONFIG;
      `PLLCG_IDX_GBL: wmask = `PLLCG_MASK_GBL;
      default: wmask = `PLLCG_MASK_DIV;
    endcase
  endfunction : wmask
  function automatic pllcg_word_t rstval(input logic [3:0] idx);
    case (idx)
      `PLLCG_IDX_CSR: rstval = `PLLCG_RST_CSR;
      `PLLCG_IDX_MULT: rstval = `PLLCG_RST_MULT;
      `PLLCG_IDX_DIV2: rstval = `PLLCG_RST_DIV_BY2;
      `PLLCG_IDX_DIV3: rstval = `PLLCG_RST_DIV_BY2;
      `PLLCG_IDX_DEVICE_CONFIG: rstval = `PLLCG_RST_DEVICE_CONFIG;
      `PLLCG_IDX_GBL: rstval = `PLLCG_RST_GBL;
      default: rstval = `PLLCG_RST_DIV_BY1;
    endcase
  endfunction : rstval

  pllcg_word_t cfg_reg [`PLLCG_NUM_RW];
  pllcg_word_t status_word;
  pllcg_path_e path_reg;
  logic [3:0] wb_idx;
  logic wb_req;
  logic [15:0] lane_mask;
  logic ref_tick;
  logic [NDIV-1:0] div_tick;
  logic [NDIV-1:0] div_wrap;
  logic [NDIV-1:0] div_level_reg;
  logic [4:0] div_cnt_reg [NDIV];
  logic [4:0] div_ratio_reg [NDIV];
  logic [2:0] memin_sync_reg;
  logic memin_filt_reg;
  logic [2:0] held_cnt_reg;
  logic held_ok_reg;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_reg;
  logic locked_reg;

  assign wb_idx = wb_adr_i[5:2];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // register file; unmapped reads return zero, writes there are dropped
  for (genvar r = 0; r < `PLLCG_NUM_RW; r++) begin : g_reg
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cfg_reg[r] <= rstval(4'(r));
      end else if (ce && wb_req && wb_we_i && wb_idx == 4'(r)) begin
        cfg_reg[r] <= (cfg_reg[r] & ~(wmask(4'(r)) & lane_mask)) |
                      (wb_dat_i[15:0] & wmask(4'(r)) & lane_mask);
      end
    end
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[`PLLCG_B_HELD] = held_ok_reg;
    status_word[`PLLCG_B_LOCKED] = locked_reg;
    status_word[`PLLCG_B_ACTPATH] = (path_reg == PLLCG_PLL);
    status_word[`PLLCG_B_ACTSRC] = cfg_reg[`PLLCG_IDX_DEVICE_CONFIG][`PLLCG_B_MEMORY_CLK_SOURCE_SEL];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_idx == `PLLCG_IDX_STATUS) begin
          wb_dat_o <= {16'h0000, status_word};
        end else if (wb_idx < `PLLCG_IDX_STATUS) begin
          wb_dat_o <= {16'h0000, cfg_reg[wb_idx]};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // status helpers: time spent in pll reset and since its release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_cnt_reg <= 3'h0;
      held_ok_reg <= 1'b0;
      lock_cnt_reg <= '0;
      locked_reg <= 1'b0;
    end else if (ce) begin
      if (pll_reset_ctl) begin
        lock_cnt_reg <= '0;
        locked_reg <= 1'b0;
        if (32'(held_cnt_reg) >= `PLLCG_RESET_CYC) begin
          held_ok_reg <= 1'b1;
        end else begin
          held_cnt_reg <= held_cnt_reg + 3'h1;
        end
      end else begin
        held_cnt_reg <= 3'h0;
        held_ok_reg <= 1'b0;
        if (32'(lock_cnt_reg) >= LOCK_CYCLES) begin
          locked_reg <= 1'b1;
        end else begin
          lock_cnt_reg <= lock_cnt_reg + 1'b1;
        end
      end
    end
  end

  // the analog loop gets its controls from the register file through one register stage, one clk later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      multiply_factor <= 5'(`PLLCG_RST_MULT);
      pll_reset_ctl <= 1'b1;
      pll_power_down <= 1'b0;
    end else if (ce) begin
      multiply_factor <= cfg_reg[`PLLCG_IDX_MULT][`PLLCG_RATIO_MSB:0];
      pll_reset_ctl <= cfg_reg[`PLLCG_IDX_CSR][`PLLCG_B_RST];
      pll_power_down <= cfg_reg[`PLLCG_IDX_CSR][`PLLCG_B_PWDN];
    end
  end

  // high-frequency reference: every clk in bypass, pll ticks otherwise
  assign ref_tick = (path_reg == PLLCG_BYPASS) ? 1'b1 : pll_output_tick;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      path_reg <= PLLCG_BYPASS;
    end else if (ce && div_wrap[CORE]) begin
      // only at a core period end, so no derived clock sees a runt pulse
      case (path_reg)
        PLLCG_BYPASS: if (cfg_reg[`PLLCG_IDX_CSR][`PLLCG_B_PATH]) path_reg <= PLLCG_PLL;
        PLLCG_PLL: if (!cfg_reg[`PLLCG_IDX_CSR][`PLLCG_B_PATH]) path_reg <= PLLCG_BYPASS;
        default: path_reg <= PLLCG_BYPASS;
      endcase
    end
  end

  assign div_tick = {1'b1, ref_tick, ref_tick, ref_tick, 1'b1};
  // all dividers start at count zero together, so core and bus stay in phase
  for (genvar d = 0; d < NDIV; d++) begin : g_div
    logic [15:0] ctl;
    logic [4:0] cnt_next;
    assign ctl = cfg_reg[`PLLCG_IDX_DIV0 + d];
    assign div_wrap[d] = div_tick[d] && div_cnt_reg[d] == div_ratio_reg[d];
    assign cnt_next = div_wrap[d] ? 5'h00 : div_cnt_reg[d] + 5'(div_tick[d]);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        div_cnt_reg[d] <= 5'h00;
        div_ratio_reg[d] <= 5'(rstval(4'(`PLLCG_IDX_DIV0 + d)));
        div_level_reg[d] <= 1'b0;
      end else if (ce) begin
        div_cnt_reg[d] <= cnt_next;
        if (div_wrap[d]) begin
          div_ratio_reg[d] <= ctl[`PLLCG_RATIO_MSB:0];
        end
        // ratio /1 holds the level high: it runs at the tick rate itself
        div_level_reg[d] <= ctl[`PLLCG_B_DEN] &&
                            (6'(cnt_next) < high_len(div_ratio_reg[d]));
      end
    end
  end

  // external memory clock pin crossing: filtered once two late stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memin_sync_reg <= 3'b000;
      memin_filt_reg <= 1'b0;
    end else if (ce) begin
      memin_sync_reg <= {memin_sync_reg[1:0], memory_clk_in};
      if (memin_sync_reg[2] == memin_sync_reg[1]) begin
        memin_filt_reg <= memin_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_reference <= 1'b0;
      core_clk <= 1'b0;
      periph_bus_clk <= 1'b0;
      memory_clk <= 1'b0;
      clk_out_two <= 1'b0;
      clk_out_three <= 1'b0;
      memory_clk_out <= 1'b0;
    end else if (ce) begin
      pll_reference <= div_level_reg[PRE];
      core_clk <= div_level_reg[CORE];
      periph_bus_clk <= div_level_reg[BUS];
      clk_out_two <= div_level_reg[BUS] && cfg_reg[`PLLCG_IDX_GBL][`PLLCG_B_CLK_OUT_TWO_EN];
      clk_out_three <= div_level_reg[OSC];
      // the memory interface runs from whichever source is selected
      memory_clk <= cfg_reg[`PLLCG_IDX_DEVICE_CONFIG][`PLLCG_B_MEMORY_CLK_SOURCE_SEL] ?
                    memin_filt_reg : div_level_reg[MEM];
      memory_clk_out <= cfg_reg[`PLLCG_IDX_GBL][`PLLCG_B_MEMORY_CLK_OUT_EN] &&
                        (cfg_reg[`PLLCG_IDX_DEVICE_CONFIG][`PLLCG_B_MEMORY_CLK_SOURCE_SEL] ?
                         memin_filt_reg : div_level_reg[MEM]);
    end
  end

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence s_bus_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_bus_ack_once: assert property (s_bus_req |=> s_bus_ack)
    else $error("bus ack not a single pulse after request");
  chk_bypass_ticks: assert property (path_reg == PLLCG_BYPASS && ce && !div_wrap[CORE]
    |=> div_cnt_reg[CORE] == $past(div_cnt_reg[CORE]) + 5'h01) else $error("bypass tick missed");
  chk_path_at_boundary: assert property (path_reg != $past(path_reg)
    |-> $past(div_wrap[CORE] && ce)) else $error("path changed away from core period boundary");
  chk_ratio_at_boundary: assert property (div_ratio_reg[BUS] != $past(div_ratio_reg[BUS])
    |-> $past(div_wrap[BUS])) else $error("bus ratio changed mid period");
  chk_count_in_range: assert property (div_cnt_reg[MEM] <= div_ratio_reg[MEM] &&
    div_cnt_reg[CORE] <= div_ratio_reg[CORE]) else $error("divider count ran past its ratio");
  chk_two_gated_off: assert property ((!cfg_reg[`PLLCG_IDX_GBL][`PLLCG_B_CLK_OUT_TWO_EN] && ce)
    [*2] |-> !clk_out_two) else $error("clock out two toggles while disabled");
  chk_three_disabled: assert property ((!cfg_reg[`PLLCG_IDX_OSC][`PLLCG_B_DEN] && ce)
    [*3] |-> !clk_out_three) else $error("clock out three runs while its divider is off");
  chk_mem_from_pin: assert property ((cfg_reg[`PLLCG_IDX_DEVICE_CONFIG][`PLLCG_B_MEMORY_CLK_SOURCE_SEL] && ce)
    ##1 ce |-> memory_clk == $past(memin_filt_reg)) else $error("memory clock not from pin");
  chk_mem_out_off: assert property ((!cfg_reg[`PLLCG_IDX_GBL][`PLLCG_B_MEMORY_CLK_OUT_EN] && ce)
    ##1 ce |-> !memory_clk_out) else $error("memory clock out driven while disabled");
  chk_reset_follows: assert property (ce |=> pll_reset_ctl ==
    $past(cfg_reg[`PLLCG_IDX_CSR][`PLLCG_B_RST])) else $error("pll reset out of step");
endmodule : pllcg_top
`default_nettype wire

// *** inc/pllcg_params.svh ***
`ifndef PLLCG_PARAMS_SVH
`define PLLCG_PARAMS_SVH

// register word indices, byte address is index times four
`define PLLCG_IDX_CSR 4'h0
`define PLLCG_IDX_MULT 4'h1
`define PLLCG_IDX_DIV0 4'h2
`define PLLCG_IDX_DIV1 4'h3
`define PLLCG_IDX_DIV2 4'h4
`define PLLCG_IDX_DIV3 4'h5
`define PLLCG_IDX_OSC 4'h6
`define PLLCG_IDX_DEVICE_CONFIG 4'h7
`define PLLCG_IDX_GBL 4'h8
`define PLLCG_IDX_STATUS 4'h9
`define PLLCG_NUM_RW 9

// field positions
`define PLLCG_B_PATH 0
`define PLLCG_B_PWDN 1
`define PLLCG_B_RST 3
`define PLLCG_B_DEN 15
`define PLLCG_B_CLK_OUT_TWO_EN 3
`define PLLCG_B_MEMORY_CLK_SOURCE_SEL 4
`define PLLCG_B_MEMORY_CLK_OUT_EN 5
`define PLLCG_B_HELD 0
`define PLLCG_B_LOCKED 1
`define PLLCG_B_ACTPATH 2
`define PLLCG_B_ACTSRC 3
`define PLLCG_RATIO_MSB 4

// writable masks and reset values
`define PLLCG_MASK_CSR 16'h000b
`define PLLCG_RST_CSR 16'h0008
`define PLLCG_MASK_MULT 16'h001f
`define PLLCG_RST_MULT 16'h0007
`define PLLCG_MASK_DIV 16'h801f
`define PLLCG_RST_DIV_BY1 16'h8000
`define PLLCG_RST_DIV_BY2 16'h8001
`define PLLCG_MASK_DEVICE_CONFIG 16'h0010
`define PLLCG_RST_DEVICE_CONFIG 16'h0000
`define PLLCG_MASK_GBL 16'h0028
`define PLLCG_RST_GBL 16'h0028

// timing
`define PLLCG_CLK_KHZ 25000
`define PLLCG_RESET_NS 125
`define PLLCG_RESET_CYC ((`PLLCG_RESET_NS * `PLLCG_CLK_KHZ + 999999) / 1000000)
`define PLLCG_LOCK_MAX_NS 187500
`define PLLCG_LOCK_CYC ((`PLLCG_LOCK_MAX_NS * `PLLCG_CLK_KHZ) / 1000000)

`endif

// *** inc/pllcg_pkg.sv ***
package pllcg_pkg;
  typedef enum logic [1:0] {
    PLLCG_BYPASS = 2'b01,
    PLLCG_PLL = 2'b10
  } pllcg_path_e;
  typedef logic [15:0] pllcg_word_t;
endpackage : pllcg_pkg

// *** verif/pll_clock_generator_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_clock_generator_tb;
  localparam int LOCK = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic pll_output_tick = 1'b0;
  logic memory_clk_in = 1'b0;
  logic pll_reference, pll_reset_ctl, pll_power_down, core_clk, periph_bus_clk;
  logic memory_clk, clk_out_two, clk_out_three, memory_clk_out, frz;
  logic [4:0] multiply_factor;
  logic [1:0] tick_cnt = 2'h0;
  logic [15:0] rd;
  int failures = 0;
  int total_checks = 0;
  logic [15:0] rst_exp [9] = '{16'h0008, 16'h0007, 16'h8000, 16'h8000, 16'h8001,
                              16'h8001, 16'h8000, 16'h0000, 16'h0028};
  int ep_t [5] = '{2, 3, 6, 5, 32};
  int eh_t [5] = '{1, 2, 3, 3, 16};

  pllcg_top #(.LOCK_CYCLES(LOCK)) pllcg_top_i (.clk(clk), .rst(rst), .ce(ce),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .pll_output_tick(pll_output_tick), .memory_clk_in(memory_clk_in),
    .pll_reference(pll_reference), .multiply_factor(multiply_factor),
    .pll_reset_ctl(pll_reset_ctl), .pll_power_down(pll_power_down),
    .core_clk(core_clk), .periph_bus_clk(periph_bus_clk), .memory_clk(memory_clk),
    .clk_out_two(clk_out_two), .clk_out_three(clk_out_three),
    .memory_clk_out(memory_clk_out));

  initial begin
    forever #20 clk = ~clk;
  end

  // pll stand-in gives one reference tick every third cycle
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    pll_output_tick <= (tick_cnt == 2'h2);
  end

  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    check(32'(wb_ack), 32'h0000_0001);
  endtask : wb

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    check(32'(rd), 32'(exp));
  endtask : rdc

  function automatic logic pick(input int idx);
    case (idx)
      0: pick = pll_reference;
      1: pick = core_clk;
      2: pick = periph_bus_clk;
      3: pick = memory_clk;
      default: pick = clk_out_three;
    endcase
  endfunction : pick

  // period and high time in clk cycles, from one rising level to the next
  task automatic measure(input int idx, input int ep, input int eh);
    logic prev;
    int n;
    int per;
    int hi;
    n = 0;
    per = 0;
    hi = 0;
    do begin
      prev = pick(idx);
      @(posedge clk);
      n++;
    end while (!(prev === 1'b0 && pick(idx) === 1'b1) && n < 300);
    do begin
      if (pick(idx) === 1'b1) hi++;
      per++;
      prev = pick(idx);
      @(posedge clk);
    end while (!(prev === 1'b0 && pick(idx) === 1'b1) && per < 300);
    check(32'(per), 32'(ep));
    check(32'(hi), 32'(eh));
  endtask : measure

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdc(6'(4 * i), rst_exp[i]);
    rdc(6'h24, 16'h0001);
    wr(6'h28, 16'hffff);
    rdc(6'h28, 16'h0000);
    check(32'(pll_reset_ctl), 32'h0000_0001);
    check(32'(clk_out_three), 32'h0000_0001);
    wr(6'h04, 16'hffff);
    rdc(6'h04, 16'h001f);
    wr(6'h04, 16'h0019);
    @(posedge clk);
    check(32'(multiply_factor), 32'h0000_0019);
    // slowing down: bus divider before core divider
    wr(6'h10, 16'h8005);
    wr(6'h0c, 16'hffe2);
    rdc(6'h0c, 16'h8002);
    wr(6'h14, 16'h8004);
    wr(6'h18, 16'h801f);
    wr(6'h08, 16'h8001);
    repeat (80) @(posedge clk);
    for (int i = 0; i < 5; i++) measure(i, ep_t[i], eh_t[i]);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      check(32'(clk_out_two), 32'(periph_bus_clk));
      check(32'(memory_clk_out), 32'(memory_clk));
    end
    wr(6'h18, 16'h001f);
    repeat (3) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      check(32'(clk_out_three), 32'h0000_0000);
    end
    wr(6'h20, 16'h0020);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      check(32'(clk_out_two), 32'h0000_0000);
    end
    wr(6'h1c, 16'h0010);
    memory_clk_in <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'(memory_clk_out), 32'h0000_0001);
    rdc(6'h24, 16'h0009);
    memory_clk_in <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(memory_clk_out), 32'h0000_0000);
    wr(6'h20, 16'h0000);
    memory_clk_in <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'(memory_clk_out), 32'h0000_0000);
    wr(6'h20, 16'h0028);
    wr(6'h1c, 16'h0000);
    // clock enable low must freeze the dividers
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    frz = core_clk;
    repeat (6) begin
      @(posedge clk);
      check(32'(core_clk), 32'(frz));
    end
    ce <= 1'b1;
    // speeding up: core divider before bus divider
    wr(6'h0c, 16'h8001);
    wr(6'h10, 16'h8003);
    wr(6'h00, 16'h0000);
    @(posedge clk);
    check(32'(pll_reset_ctl), 32'h0000_0000);
    wb(1'b0, 6'h24, 16'h0000);
    check(32'(rd[1]), 32'h0000_0000);
    repeat (LOCK + 5) @(posedge clk);
    wb(1'b0, 6'h24, 16'h0000);
    check(32'(rd[1]), 32'h0000_0001);
    repeat (40) @(posedge clk);
    measure(1, 2, 1);
    wr(6'h00, 16'h0001);
    repeat (60) @(posedge clk);
    wb(1'b0, 6'h24, 16'h0000);
    check(32'(rd[2]), 32'h0000_0001);
    measure(1, 6, 3);
    measure(2, 12, 6);
    wr(6'h00, 16'h0000);
    repeat (40) @(posedge clk);
    measure(1, 2, 1);
    wr(6'h00, 16'h000a);
    repeat (10) @(posedge clk);
    wb(1'b0, 6'h24, 16'h0000);
    check(32'(rd[0]), 32'h0000_0001);
    check(32'(pll_reset_ctl), 32'h0000_0001);
    check(32'(pll_power_down), 32'h0000_0001);
    print_verdict();
  end
endmodule : pll_clock_generator_tb
`default_nettype wire
